// [csf_params.svh]
// constants for the cpu status flag block
//
// Summary of operation
// [RULE1] the three-bit priority field in status bits 7..5 holds the priority 0..7 in binary, 7 masking user interrupts.
// [RULE2] the effective priority is four bits: the field plus the msb held in the core control word, msb set meaning value plus 8 and user interrupts masked.
// [RULE3] while the nesting disable control bit is 1, software writes to the priority field are ignored.
// [RULE4] the negative flag in bit 3 is 1 after a negative result and 0 after a zero or positive one.
// [RULE5] the overflow flag in bit 2 is 1 after a signed overflow that wrongly flips the sign, else 0.
// [RULE6] the zero flag in bit 1 is cleared by a non-zero result of a zero-affecting operation and otherwise holds; the code also sets it on a zero result.
// [RULE7] the carry flag in bit 0 is 1 when a carry leaves the result msb, else 0.
// [RULE8] a read-or-clear flag accepts only clearing writes; writing 1 to it has no effect.
// [RULE9] clearing the combined accumulator saturation flag also clears both accumulator saturation flags.
// [RULE10] flags an operation does not affect hold, and every update lands at the end of the completing cycle.
`ifndef CSF_PARAMS_SVH
`define CSF_PARAMS_SVH
// ==========================================================
// register offsets
`define CSF_OFS_STATUS 4'h0
`define CSF_OFS_CORE_CTL 4'h1
`define CSF_OFS_INT_CTL 4'h2
`define CSF_OFS_IRQ_STAT 4'h3
`define CSF_OFS_IRQ_MASK 4'h4
// ==========================================================
// status and control word fields
`define CSF_BIT_CARRY 0
`define CSF_BIT_ZERO 1
`define CSF_BIT_OVF 2
`define CSF_BIT_NEG 3
`define CSF_IPL_LO 5
`define CSF_IPL_HI 7
`define CSF_BIT_SAT_AB 13
`define CSF_BIT_SAT_B 14
`define CSF_BIT_SAT_A 15
`define CSF_BIT_IPL_MSB 3
`define CSF_BIT_NESTING_DISABLE_CTL 15
`define CSF_IPL_USER_OFF 3'h7
// ==========================================================
// reset values
`define CSF_RST_STATUS 16'h0000
`define CSF_RST_CORE_CTL 16'h0000
`define CSF_RST_INT_CTL 16'h0000
`define CSF_RST_IRQ_MASK 4'h0
`endif

// [csf_pkg.sv]
// types for the cpu status flag block
package csf_pkg;
  typedef struct packed {
    logic neg;
    logic ovf;
    logic zero;
    logic carry;
  } csf_flags_t;
  typedef struct packed {
    logic valid;
    logic upd_neg;
    logic upd_ovf;
    logic upd_zero;
    logic upd_carry;
    csf_flags_t flags;
  } csf_alu_t;
  typedef struct packed {
    logic sat_a;
    logic sat_b;
  } csf_sat_t;
endpackage

// [csf_flag_merge.sv]
// merges alu flag results into the held flags
`timescale 1ns/100ps
module csf_flag_merge (
  input wire csf_pkg::csf_flags_t i_held,
  input wire csf_pkg::csf_alu_t i_alu,
  output csf_pkg::csf_flags_t o_next
);
  import csf_pkg::*;
  always_comb begin
    o_next = i_held;
    if (i_alu.valid) begin
      if (i_alu.upd_neg) begin
        o_next.neg = i_alu.flags.neg; // RULE4
      end
      if (i_alu.upd_ovf) begin
        o_next.ovf = i_alu.flags.ovf; // RULE5
      end
      // zero flag follows the result: a zero result sets it, a non-zero one clears it
      if (i_alu.upd_zero && !i_alu.flags.zero) begin
        o_next.zero = 1'b0; // RULE6
      end else if (i_alu.upd_zero) begin
        o_next.zero = 1'b1; // RULE6
      end
      if (i_alu.upd_carry) begin
        o_next.carry = i_alu.flags.carry; // RULE7
      end
    end
  end
endmodule // csf_flag_merge

// [csf_irq.sv]
// sticky event status with mask and one level interrupt
`timescale 1ns/100ps
module csf_irq #(
  parameter int N = 4
) (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire logic [N-1:0] i_event,
  input wire logic i_clr_we,
  input wire logic [N-1:0] i_clr_bits,
  input wire logic i_mask_we,
  input wire logic [N-1:0] i_mask_bits,
  output logic [N-1:0] o_status,
  output logic [N-1:0] o_mask,
  output logic o_irq
);
  logic [N-1:0] stat_r, stat_nxt, mask_r, mask_nxt;
  // elaboration guard: a zero-wide event vector cannot be served
  if (N < 1) begin : g_bad_n
    $error("csf_irq needs at least one event");
  end
  always_comb begin
    // set wins over a clear in the same cycle
    stat_nxt = (i_clr_we ? (stat_r & ~i_clr_bits) : stat_r) | i_event;
    mask_nxt = i_mask_we ? i_mask_bits : mask_r;
  end
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      stat_r <= '0;
      mask_r <= '0;
    end else begin
      stat_r <= stat_nxt;
      mask_r <= mask_nxt;
    end
  end
  assign o_status = stat_r;
  assign o_mask = mask_r;
  assign o_irq = |(stat_r & mask_r);
endmodule // csf_irq

// [csf_status.sv]
// cpu status word low half, priority level and saturation flags
`timescale 1ns/100ps
`include "csf_params.svh"
module csf_status (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire csf_pkg::csf_alu_t i_alu,
  input wire csf_pkg::csf_sat_t i_sat_set,
  input wire logic i_ipl_hw_we,
  input wire logic [2:0] i_ipl_hw,
  input wire logic [3:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [15:0] o_rdata,
  output logic [15:0] o_cpu_status_word,
  output logic [3:0] o_priority_level,
  output logic o_user_irq_disable,
  output logic o_irq
);
  import csf_pkg::*;

  // ==========================================================
  // state
  csf_flags_t flags_r, flags_nxt, merged;
  logic [2:0] ipl_r, ipl_nxt;
  csf_sat_t sat_r, sat_nxt;
  logic sat_ab_r, sat_ab_nxt;
  logic [15:0] core_ctl_r, core_ctl_nxt;
  logic [15:0] int_ctl_r, int_ctl_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  logic [3:0] irq_stat, irq_mask, events;
  logic wr_status, wr_clr, wr_mask;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
    hit = (a == ofs);
  endfunction

  assign wr_status = i_wr && hit(i_addr, `CSF_OFS_STATUS);
  assign wr_clr = i_wr && hit(i_addr, `CSF_OFS_IRQ_STAT);
  assign wr_mask = i_wr && hit(i_addr, `CSF_OFS_IRQ_MASK);

  // ==========================================================
  // alu flag update
  csf_flag_merge u_merge (
    .i_held(flags_r),
    .i_alu(i_alu),
    .o_next(merged)
  );

  always_comb begin
    flags_nxt = flags_r;
    ipl_nxt = ipl_r;
    sat_nxt = sat_r;
    sat_ab_nxt = sat_ab_r;
    core_ctl_nxt = core_ctl_r;
    int_ctl_nxt = int_ctl_r;
    // software write first, alu result in the same cycle takes over
    if (wr_status) begin
      flags_nxt.neg = i_wdata[`CSF_BIT_NEG];
      flags_nxt.ovf = i_wdata[`CSF_BIT_OVF];
      flags_nxt.zero = i_wdata[`CSF_BIT_ZERO];
      flags_nxt.carry = i_wdata[`CSF_BIT_CARRY];
      if (!int_ctl_r[`CSF_BIT_NESTING_DISABLE_CTL]) begin
        ipl_nxt = i_wdata[`CSF_IPL_HI:`CSF_IPL_LO]; // RULE3
      end
      // saturation flags are read-or-clear only
      if (!i_wdata[`CSF_BIT_SAT_A]) sat_nxt.sat_a = 1'b0; // RULE8
      if (!i_wdata[`CSF_BIT_SAT_B]) sat_nxt.sat_b = 1'b0; // RULE8
      if (!i_wdata[`CSF_BIT_SAT_AB]) begin
        sat_ab_nxt = 1'b0; // RULE8
        sat_nxt = '0; // RULE9
      end
    end
    if (i_alu.valid) begin
      flags_nxt = merged; // RULE10
    end
    // hardware priority change from the interrupt controller is not gated
    if (i_ipl_hw_we) begin
      ipl_nxt = i_ipl_hw; // RULE1
    end
    // saturation events set over a clearing write
    if (i_sat_set.sat_a) begin
      sat_nxt.sat_a = 1'b1;
      sat_ab_nxt = 1'b1;
    end
    if (i_sat_set.sat_b) begin
      sat_nxt.sat_b = 1'b1;
      sat_ab_nxt = 1'b1;
    end
    if (i_wr && hit(i_addr, `CSF_OFS_CORE_CTL)) core_ctl_nxt = i_wdata;
    if (i_wr && hit(i_addr, `CSF_OFS_INT_CTL)) int_ctl_nxt = i_wdata;
  end

  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      flags_r <= '0;
      ipl_r <= 3'h0;
      sat_r <= '0;
      sat_ab_r <= 1'b0;
      core_ctl_r <= `CSF_RST_CORE_CTL;
      int_ctl_r <= `CSF_RST_INT_CTL;
    end else begin
      flags_r <= flags_nxt;
      ipl_r <= ipl_nxt;
      sat_r <= sat_nxt;
      sat_ab_r <= sat_ab_nxt;
      core_ctl_r <= core_ctl_nxt;
      int_ctl_r <= int_ctl_nxt;
    end
  end

  // ==========================================================
  // status word and priority
  always_comb begin
    o_cpu_status_word = `CSF_RST_STATUS;
    o_cpu_status_word[`CSF_BIT_NEG] = flags_r.neg; // RULE4
    o_cpu_status_word[`CSF_BIT_OVF] = flags_r.ovf; // RULE5
    o_cpu_status_word[`CSF_BIT_ZERO] = flags_r.zero; // RULE6
    o_cpu_status_word[`CSF_BIT_CARRY] = flags_r.carry; // RULE7
    o_cpu_status_word[`CSF_IPL_HI:`CSF_IPL_LO] = ipl_r; // RULE1
    o_cpu_status_word[`CSF_BIT_SAT_A] = sat_r.sat_a;
    o_cpu_status_word[`CSF_BIT_SAT_B] = sat_r.sat_b;
    o_cpu_status_word[`CSF_BIT_SAT_AB] = sat_ab_r;
  end

  assign o_priority_level = {core_ctl_r[`CSF_BIT_IPL_MSB], ipl_r}; // RULE2
  assign o_user_irq_disable = core_ctl_r[`CSF_BIT_IPL_MSB] ||
    (ipl_r == `CSF_IPL_USER_OFF); // RULE1 RULE2

  // ==========================================================
  // events: negative, overflow, carry, saturation
  assign events = {i_sat_set.sat_a | i_sat_set.sat_b,
    i_alu.valid & i_alu.upd_carry & i_alu.flags.carry,
    i_alu.valid & i_alu.upd_ovf & i_alu.flags.ovf,
    i_alu.valid & i_alu.upd_neg & i_alu.flags.neg};

  csf_irq #(.N(4)) u_irq (
    .i_mclk(i_mclk),
    .i_sys_rst(i_sys_rst),
    .i_event(events),
    .i_clr_we(wr_clr),
    .i_clr_bits(i_wdata[3:0]),
    .i_mask_we(wr_mask),
    .i_mask_bits(i_wdata[3:0]),
    .o_status(irq_stat),
    .o_mask(irq_mask),
    .o_irq(o_irq)
  );

  // ==========================================================
  // register read, data one cycle after the strobe
  always_comb begin
    rdata_nxt = 16'h0000;
    if (i_rd) begin
      case (i_addr)
        `CSF_OFS_STATUS: rdata_nxt = o_cpu_status_word;
        `CSF_OFS_CORE_CTL: rdata_nxt = core_ctl_r;
        `CSF_OFS_INT_CTL: rdata_nxt = int_ctl_r;
        `CSF_OFS_IRQ_STAT: rdata_nxt = {12'h000, irq_stat};
        `CSF_OFS_IRQ_MASK: rdata_nxt = {12'h000, irq_mask};
        default: rdata_nxt = 16'h0000;
      endcase
    end
  end
  always_ff @(posedge i_mclk) begin
    if (i_sys_rst) begin
      rdata_r <= 16'h0000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end
  assign o_rdata = rdata_r;
endmodule // csf_status

// [csf_status_props.sv]
// assertion checker for the cpu status flag block
`timescale 1ns/100ps
module csf_status_props (
  input wire logic i_mclk,
  input wire logic i_sys_rst,
  input wire csf_pkg::csf_alu_t i_alu,
  input wire csf_pkg::csf_sat_t i_sat_set,
  input wire logic i_ipl_hw_we,
  input wire logic [3:0] i_addr,
  input wire logic [15:0] i_wdata,
  input wire logic i_wr,
  input wire logic [15:0] o_cpu_status_word,
  input wire logic [3:0] o_priority_level,
  input wire logic o_user_irq_disable
);
  import csf_pkg::*;
  // ==========================================
  // shadow of the nesting disable bit
  logic nest_r;
  logic nest_nxt;
  logic sw_r;
  logic [15:0] w;
  assign w = o_cpu_status_word;
  assign sw_r = i_wr && i_addr == 4'h0;
  always_comb begin
    nest_nxt = nest_r;
    if (i_wr && i_addr == 4'h2) nest_nxt = i_wdata[15];
  end
  always_ff @(posedge i_mclk) nest_r <= i_sys_rst ? 1'b0 : nest_nxt;
  // ==========================================
  // properties
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_sys_rst);
  AST_PRIO: assert property (o_priority_level[2:0] == w[7:5])
    else $error("priority field mismatch");
  AST_USER: assert property (o_user_irq_disable == (o_priority_level[3] || w[7:5] == 3'h7))
    else $error("user interrupt disable wrong");
  AST_NEST: assert property (sw_r && nest_r && !i_ipl_hw_we |=> $stable(w[7:5]))
    else $error("locked priority field changed");
  AST_NEG: assert property (i_alu.valid && i_alu.upd_neg |=> w[3] == $past(i_alu.flags.neg))
    else $error("negative flag wrong");
  AST_OVF: assert property (i_alu.valid && i_alu.upd_ovf |=> w[2] == $past(i_alu.flags.ovf))
    else $error("overflow flag wrong");
  AST_ZERO: assert property (i_alu.valid && i_alu.upd_zero && !i_alu.flags.zero |=> !w[1])
    else $error("zero flag not cleared");
  AST_CARRY: assert property (i_alu.valid && i_alu.upd_carry |=> w[0] == $past(i_alu.flags.carry))
    else $error("carry flag wrong");
  AST_SAT_W1: assert property (sw_r && i_wdata[15:13] == 3'h7 && i_sat_set == 2'h0 |=> $stable(w[15:13]))
    else $error("saturation flag set by software");
  AST_SAT_CLR: assert property (sw_r && !i_wdata[13] && i_sat_set == 2'h0 |=> w[15:13] == 3'h0)
    else $error("saturation flags not cleared");
  AST_HOLD: assert property (!i_alu.valid && !sw_r |=> $stable(w[3:0]))
    else $error("flags moved without an update");
endmodule // csf_status_props

// [csf_alu_model.sv]
// alu stand-in that turns an addition into flag results
`timescale 1ns/100ps
module csf_alu_model (
  input wire logic i_go,
  input wire logic [15:0] i_a,
  input wire logic [15:0] i_b,
  input wire logic [3:0] i_upd,
  output csf_pkg::csf_alu_t o_alu
);
  import csf_pkg::*;
  logic [16:0] sum;
  logic ovf;
  assign sum = {1'b0, i_a} + {1'b0, i_b};
  // overflow only when like signs give a result of the other sign
  assign ovf = (i_a[15] == i_b[15]) && (sum[15] != i_a[15]);
  assign o_alu = {i_go, i_upd, sum[15], ovf, sum[15:0] == 16'h0000, sum[16]};
endmodule // csf_alu_model

// [test_cpu_status_flags.sv]
// self-checking bench for the cpu status flag block
`timescale 1ns/100ps
module test_cpu_status_flags;
  import csf_pkg::*;
  logic i_mclk = 0, i_sys_rst = 1, i_wr = 0, i_rd = 0, go = 0, i_ipl_hw_we = 0, o_irq;
  logic [15:0] a = 0, b = 0, i_wdata = 0, o_rdata, o_cpu_status_word;
  logic [3:0] i_addr = 0, upd = 0, o_priority_level;
  logic [2:0] i_ipl_hw = 0;
  logic o_user_irq_disable;
  csf_sat_t i_sat_set = '0;
  csf_alu_t alu;
  int n_fail = 0, n_compared = 0, cyc = 0;
  always #4 i_mclk = ~i_mclk;
  csf_alu_model u_alu (.i_go(go), .i_a(a), .i_b(b), .i_upd(upd), .o_alu(alu));
  csf_status DUT (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_alu(alu), .i_sat_set(i_sat_set),
    .i_ipl_hw_we(i_ipl_hw_we), .i_ipl_hw(i_ipl_hw), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_cpu_status_word(o_cpu_status_word),
    .o_priority_level(o_priority_level), .o_user_irq_disable(o_user_irq_disable), .o_irq(o_irq));
  // ==========================================
  // shared tasks
  task check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task end_sim;
    $display("compared %0d mismatches %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task wr(input logic [3:0] ad, input logic [15:0] d);
    @(posedge i_mclk);
    i_wr <= 1;
    i_addr <= ad;
    i_wdata <= d;
    @(posedge i_mclk);
    i_wr <= 0;
    #1;
  endtask
  task rd(input logic [3:0] ad, input logic [15:0] exp);
    @(posedge i_mclk);
    i_rd <= 1;
    i_addr <= ad;
    @(posedge i_mclk);
    i_rd <= 0;
    #1;
    check(o_rdata, exp);
  endtask
  // one alu beat; the flag word is settled one cycle later
  task op(input logic [15:0] x, input logic [15:0] y, input logic [3:0] u, input logic [15:0] e);
    @(posedge i_mclk);
    a <= x;
    b <= y;
    upd <= u;
    go <= 1;
    @(posedge i_mclk);
    go <= 0;
    #1;
    check(o_cpu_status_word, e);
  endtask
  // ==========================================
  // scenarios
  task t_flags;
    #1;
    check(o_cpu_status_word, 16'h0000);
    check(16'(o_priority_level), 16'h0000);
    op(16'h7FFF, 16'h0001, 4'hF, 16'h000C);
    op(16'hFFFF, 16'h0001, 4'hF, 16'h0003);
    op(16'h8000, 16'h8000, 4'hF, 16'h0007);
    op(16'h0001, 16'h0001, 4'h0, 16'h0007);
    op(16'h0001, 16'h0001, 4'h2, 16'h0005);
    op(16'h0000, 16'h0000, 4'h1, 16'h0004);
    // events are latched but masked after reset, so no interrupt yet
    check(16'(o_irq), 16'h0000);
    rd(4'h3, 16'h0007);
    wr(4'h4, 16'h000F);
    check(16'(o_irq), 16'h0001);
    wr(4'h3, 16'h000F);
    check(16'(o_irq), 16'h0000);
    rd(4'h3, 16'h0000);
    wr(4'h4, 16'h0000);
    $display("flag test done");
  endtask
  task t_ipl;
    for (int v = 0; v < 16; v++) begin
      wr(4'h1, {12'h000, v[3], 3'h0});
      wr(4'h0, {8'h00, v[2:0], 5'h00});
      check(16'(o_priority_level), 16'(v));
      check(16'(o_user_irq_disable), 16'(v[3] || v[2:0] == 3'h7));
    end
    wr(4'h1, 16'h0000);
    wr(4'h2, 16'h8000);
    wr(4'h0, 16'h00A0);
    check(16'(o_priority_level), 16'h0007);
    @(posedge i_mclk);
    i_ipl_hw_we <= 1;
    i_ipl_hw <= 3'h5;
    @(posedge i_mclk);
    i_ipl_hw_we <= 0;
    #1;
    check(16'(o_priority_level), 16'h0005);
    wr(4'h2, 16'h0000);
    wr(4'h0, 16'h0060);
    check(16'(o_priority_level), 16'h0003);
    rd(4'hF, 16'h0000);
    $display("priority test done");
  endtask
  task t_sat;
    @(posedge i_mclk);
    i_sat_set <= 2'h3;
    @(posedge i_mclk);
    i_sat_set <= 2'h0;
    #1;
    check(o_cpu_status_word & 16'hE0E0, 16'hE060);
    rd(4'h3, 16'h0008);
    wr(4'h0, 16'hE060);
    check(o_cpu_status_word & 16'hE0E0, 16'hE060);
    wr(4'h0, 16'hC060);
    check(o_cpu_status_word & 16'hE0E0, 16'h0060);
    wr(4'h0, 16'hE060);
    check(o_cpu_status_word & 16'hE0E0, 16'h0060);
    wr(4'h3, 16'h000F);
    $display("saturation test done");
  endtask
  task t_rst;
    wr(4'h2, 16'h8000);
    @(posedge i_mclk);
    i_sys_rst <= 1;
    repeat (2) @(posedge i_mclk);
    i_sys_rst <= 0;
    #1;
    check(o_cpu_status_word, 16'h0000);
    check(16'(o_priority_level), 16'h0000);
    rd(4'h2, 16'h0000);
    $display("reset test done");
  endtask
  // ==========================================
  // main sequence and hang guard
  initial begin
    repeat (3) @(posedge i_mclk);
    i_sys_rst <= 0;
    t_flags;
    t_ipl;
    t_sat;
    t_rst;
    end_sim;
  end
  always @(posedge i_mclk) begin
    cyc++;
    if (cyc == 2000) begin
      n_fail++;
      end_sim;
    end
  end
endmodule // test_cpu_status_flags
bind csf_status csf_status_props u_props (.i_mclk(i_mclk), .i_sys_rst(i_sys_rst), .i_alu(i_alu),
  .i_sat_set(i_sat_set), .i_ipl_hw_we(i_ipl_hw_we), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .o_cpu_status_word(o_cpu_status_word), .o_priority_level(o_priority_level),
  .o_user_irq_disable(o_user_irq_disable));
